// file: logic/dcut_pkg.sv
// constants and carrier types for the dual uart counter/timer
package dcut_pkg;

   // register offsets on the 4-bit parallel bus
   localparam logic [3:0] AUX_CONTROL_REG_ADDR    = 4'h4;
   localparam logic [3:0] IRQ_STATUS_REG_ADDR     = 4'h5;
   localparam logic [3:0] IRQ_MASK_REG_ADDR       = 4'h5;
   localparam logic [3:0] RELOAD_UPPER_BYTE_ADDR  = 4'h6;
   localparam logic [3:0] LIVE_COUNT_UPPER_ADDR   = 4'h6;
   localparam logic [3:0] RELOAD_LOWER_BYTE_ADDR  = 4'h7;
   localparam logic [3:0] LIVE_COUNT_LOWER_ADDR   = 4'h7;
   localparam logic [3:0] OUTPORT_CONFIG_REG_ADDR = 4'hD;
   localparam logic [3:0] START_COMMAND_ADDR      = 4'hE;
   localparam logic [3:0] STOP_COMMAND_ADDR       = 4'hF;

   // field positions
   localparam int CT_READY_BIT   = 3;
   localparam int CT_MODE_BIT    = 6;
   localparam int CT_SRC_MSB     = 5;
   localparam int CT_SRC_LSB     = 4;
   localparam int OUTPORT_CONFIG_REG_PIN3_MSB  = 3;
   localparam int OUTPORT_CONFIG_REG_PIN3_LSB  = 2;

   // field encodings
   localparam logic [1:0] SRC_EXT         = 2'h0;
   localparam logic [1:0] SRC_EXT_DIV16   = 2'h1;
   localparam logic [1:0] SRC_XTAL        = 2'h2;
   localparam logic [1:0] SRC_XTAL_DIV16  = 2'h3;
   localparam logic [1:0] PIN3_SHOWS_CT   = 2'h1;

   // reset values
   localparam logic [7:0]  AUX_CONTROL_RESET = 8'h00;
   localparam logic [7:0]  IRQ_MASK_RESET    = 8'h00;
   localparam logic [7:0]  OUTPORT_RESET     = 8'h00;
   localparam logic [7:0]  RELOAD_RESET      = 8'h00;
   localparam logic [15:0] COUNT_RESET       = 16'h0000;
   localparam logic [7:0]  READ_ZERO         = 8'h00;

   // timing counts
   localparam logic [3:0]  PRESCALE_LAST     = 4'hF;
   localparam logic [15:0] TERMINAL_STEP     = 16'h0001;

   typedef enum logic [1:0] {
      ST_HALTED = 2'b00,
      ST_COUNT  = 2'b01,
      ST_TIMER  = 2'b10
   } dcut_state_t;

   // host side of the parallel register bus, all strobes active low
   typedef struct packed {
      logic       csN;
      logic       rdN;
      logic       wrN;
      logic [3:0] addr;
      logic [7:0] wrData;
   } dcut_bus_t;

   // receive-to-fifo transfer events from both channels
   typedef struct packed {
      logic timeoutEnA;
      logic timeoutEnB;
      logic fifoLoadA;
      logic fifoLoadB;
   } dcut_rx_t;

endpackage

// file: logic/dcut_counter_timer.sv
// 16-bit counter/timer of a dual uart with its byte registers
//
// What this block does
// R01 - 16-bit down counter, counter or timer mode
// R02 - reload is upper:lower byte, rewritable anytime
// R03 - reset leaves the unit in counter mode
// R04 - counter start read loads reload, starts counting
// R05 - counter step 1 to 0 sets status bit 3
// R06 - status bit 3 and mask bit 3 assert irq
// R07 - counter wraps to FFFF and keeps counting
// R08 - counter uses new reload only on start or rx fifo load
// R09 - counter stop read halts and clears bit 3
// R10 - software reads count bytes only while stopped; the block returns the live count bytes at any time
// R11 - rx fifo load reloads, counting resumes next tick
// R12 - timeout at zero raises bit 3 interrupt
// R13 - timeout attached to one channel only
// R14 - timer stop read only clears bit 3
// R15 - timer start read forces output high, reloads
// R16 - timer zero toggles output and auto reloads
// R17 - square wave period is twice reload ticks
// R18 - timer sets bit 3 on each terminal-count rising edge
// R19 - timer new reload at terminal count or start
// R20 - timer square wave feeds channel baud clocks
// R21 - aux field picks source, outport_config_reg routes pin 3
// R22 - software starts timer before routing pin 3
// R23 - count reads return live upper/lower byte
`timescale 1ns/1ps

module dcut_counter_timer
   import dcut_pkg::*;
(
   input  wire logic      sys_clk,
   input  wire logic      reset_n,
   input  wire dcut_bus_t busIn,
   input  wire dcut_rx_t  rxIn,
   input  wire logic      extTick,
   input  wire logic      xtalTick,
   input  wire logic      outPortBit3,
   output logic [7:0]     rdData_ff,
   output logic           irqReqN_ff,
   output logic           ctOut_ff,
   output logic           baudClk_ff,
   output logic           timerOutPin_ff
);

   // the count wraps 0000 to FFFF by plain subtraction
   function automatic logic [15:0] stepDown(input logic [15:0] value);
      stepDown = value - TERMINAL_STEP;
   endfunction

   function automatic logic isAt(input logic [3:0] a, input logic [3:0] target);
      isAt = (a == target);
   endfunction

   logic [7:0]  auxControl_ff;
   logic [7:0]  irqMask_ff;
   logic [7:0]  outportConfig_ff;
   logic [7:0]  reloadUpper_ff;
   logic [7:0]  reloadLower_ff;
   logic [15:0] count_ff;
   logic        ctReady_ff;
   logic        busBusy_ff;
   logic [3:0]  extDiv_ff;
   logic [3:0]  xtalDiv_ff;
   logic        timeoutLoadQ_ff;
   dcut_state_t state_ff;

   logic        accessStart;
   logic        rdStart;
   logic        wrStart;
   logic        startCmd;
   logic        stopCmd;
   logic        timerMode;
   logic [15:0] reloadValue;
   logic        ctTick;
   logic        timeoutLoad;
   logic        atTerminal;
   logic        setReady;
   logic        clrReady;
   dcut_state_t nxt_state;
   logic [15:0] nxt_count;
   logic        nxt_ctOut;

   // per-register write strobes, divided ticks and read mux
   logic        wrAuxControl;
   logic        wrIrqMask;
   logic        wrOutportConfig;
   logic        wrReloadUpper;
   logic        wrReloadLower;
   logic        extDivTick;
   logic        xtalDivTick;
   logic [7:0]  nxt_rdData;

   // a bus access counts once, at the first cycle of chip select with a strobe low
   assign accessStart = ~busIn.csN & ~busBusy_ff & (~busIn.rdN | ~busIn.wrN);
   assign rdStart     = accessStart & ~busIn.rdN;
   assign wrStart     = accessStart & ~busIn.wrN & busIn.rdN;
   assign startCmd    = rdStart & isAt(busIn.addr, START_COMMAND_ADDR);
   assign stopCmd     = rdStart & isAt(busIn.addr, STOP_COMMAND_ADDR);
   assign timerMode   = auxControl_ff[CT_MODE_BIT];
   assign reloadValue = {reloadUpper_ff, reloadLower_ff};                        // [R02]

   // one strobe per register; reload offsets are shared with the count reads
   assign wrAuxControl    = wrStart & isAt(busIn.addr, AUX_CONTROL_REG_ADDR);
   assign wrIrqMask       = wrStart & isAt(busIn.addr, IRQ_MASK_REG_ADDR);
   assign wrOutportConfig = wrStart & isAt(busIn.addr, OUTPORT_CONFIG_REG_ADDR);
   assign wrReloadUpper   = wrStart & isAt(busIn.addr, RELOAD_UPPER_BYTE_ADDR);
   assign wrReloadLower   = wrStart & isAt(busIn.addr, RELOAD_LOWER_BYTE_ADDR);

   // busy keeps a held strobe from counting as a second access
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         busBusy_ff <= 1'b0;
      end else begin
         busBusy_ff <= ~busIn.csN & (~busIn.rdN | ~busIn.wrN);
      end
   end

   // write-only control registers, one flop group per register
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         auxControl_ff <= AUX_CONTROL_RESET;                                     // [R03]
      end else if (wrAuxControl) begin
         auxControl_ff <= busIn.wrData;                                          // [R21]
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         irqMask_ff <= IRQ_MASK_RESET;
      end else if (wrIrqMask) begin
         irqMask_ff <= busIn.wrData;                                             // [R06]
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         outportConfig_ff <= OUTPORT_RESET;
      end else if (wrOutportConfig) begin
         outportConfig_ff <= busIn.wrData;                                       // [R21]
      end
   end

   // reload bytes, writable at any moment; the count only sees them on a load
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         reloadUpper_ff <= RELOAD_RESET;
      end else if (wrReloadUpper) begin
         reloadUpper_ff <= busIn.wrData;                                         // [R02]
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         reloadLower_ff <= RELOAD_RESET;
      end else if (wrReloadLower) begin
         reloadLower_ff <= busIn.wrData;                                         // [R02]
      end
   end

   // divide-by-16 prescalers for the two tick sources
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         extDiv_ff  <= 4'h0;
         xtalDiv_ff <= 4'h0;
      end else begin
         if (extTick) begin
            extDiv_ff <= extDiv_ff + 4'h1;
         end
         if (xtalTick) begin
            xtalDiv_ff <= xtalDiv_ff + 4'h1;
         end
      end
   end

   // a divided tick is the source tick that wraps its prescaler
   assign extDivTick  = extTick & (extDiv_ff == PRESCALE_LAST);
   assign xtalDivTick = xtalTick & (xtalDiv_ff == PRESCALE_LAST);

   // clock source select from the aux field
   always_comb begin
      unique case (auxControl_ff[CT_SRC_MSB:CT_SRC_LSB])                         // [R21]
         SRC_EXT:        ctTick = extTick;
         SRC_EXT_DIV16:  ctTick = extDivTick;
         SRC_XTAL:       ctTick = xtalTick;
         SRC_XTAL_DIV16: ctTick = xtalDivTick;
      endcase
   end

   // channel a wins when both ask, so only one channel ever drives the reload
   assign timeoutLoad = rxIn.timeoutEnA ? rxIn.fifoLoadA                         // [R13]
                                        : (rxIn.timeoutEnB & rxIn.fifoLoadB);

   // the load lands one cycle later so a tick in the same cycle is not counted
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         timeoutLoadQ_ff <= 1'b0;
      end else begin
         timeoutLoadQ_ff <= timeoutLoad & ~timerMode;
      end
   end

   // terminal is the tick that takes the count from 1 to 0
   assign atTerminal = ctTick & (count_ff == TERMINAL_STEP);

   // count, run state and square wave
   always_comb begin
      nxt_state = state_ff;
      nxt_count = count_ff;
      nxt_ctOut = ctOut_ff;
      setReady  = 1'b0;
      unique case (state_ff)
         ST_HALTED: begin
            if (startCmd) begin
               nxt_count = reloadValue;                                          // [R04] [R08]
               nxt_state = timerMode ? ST_TIMER : ST_COUNT;                      // [R01]
               nxt_ctOut = 1'b1;                                                 // [R15]
            end else if (timeoutLoadQ_ff) begin
               nxt_count = reloadValue;                                          // [R11]
               nxt_state = ST_COUNT;
            end
         end
         ST_COUNT: begin
            if (startCmd) begin
               nxt_count = reloadValue;                                          // [R04] [R08]
               nxt_state = timerMode ? ST_TIMER : ST_COUNT;
               nxt_ctOut = 1'b1;
            end else if (stopCmd) begin
               nxt_state = ST_HALTED;                                            // [R09]
            end else if (timeoutLoadQ_ff) begin
               nxt_count = reloadValue;                                          // [R11]
            end else if (ctTick) begin
               nxt_count = stepDown(count_ff);                                   // [R07]
               setReady  = atTerminal;                                           // [R05] [R12]
               if (atTerminal) begin
                  nxt_ctOut = ~ctOut_ff;
               end
            end
         end
         ST_TIMER: begin
            if (startCmd) begin
               nxt_count = reloadValue;                                          // [R15] [R19]
               nxt_ctOut = 1'b1;                                                 // [R15]
               nxt_state = timerMode ? ST_TIMER : ST_COUNT;
            end else if (atTerminal) begin
               // half period is reload ticks, so the full wave is twice that
               nxt_count = reloadValue;                                          // [R16] [R17] [R19]
               nxt_ctOut = ~ctOut_ff;                                            // [R16]
               setReady  = ~ctOut_ff;                                            // [R18]
            end else if (ctTick) begin
               nxt_count = stepDown(count_ff);                                   // [R01]
            end
         end
         default: begin
            nxt_state = ST_HALTED;
         end
      endcase
   end

   // reset leaves the unit halted in counter mode
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ST_HALTED;                                                  // [R03]
         count_ff <= COUNT_RESET;
         ctOut_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         count_ff <= nxt_count;
         ctOut_ff <= nxt_ctOut;
      end
   end

   // stop clears the ready flag in both modes; a terminal count in the same cycle wins in timer mode only
   assign clrReady = stopCmd;                                                    // [R09] [R14]

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctReady_ff <= 1'b0;
      end else if (setReady) begin
         ctReady_ff <= 1'b1;                                                     // [R05] [R18]
      end else if (clrReady) begin
         ctReady_ff <= 1'b0;                                                     // [R09] [R14]
      end
   end

   // interrupt request lags the flag by one cycle to stay a clean flop output
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         irqReqN_ff <= 1'b1;
      end else begin
         irqReqN_ff <= ~(ctReady_ff & irqMask_ff[CT_READY_BIT]);                 // [R06] [R12]
      end
   end

   // baud source follows the wave one cycle behind
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         baudClk_ff <= 1'b1;
      end else begin
         baudClk_ff <= ctOut_ff;                                                 // [R20]
      end
   end

   // pin 3 shows the wave only when routed, else the port bit
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         timerOutPin_ff <= 1'b0;
      end else if (outportConfig_ff[OUTPORT_CONFIG_REG_PIN3_MSB:OUTPORT_CONFIG_REG_PIN3_LSB] == PIN3_SHOWS_CT) begin
         timerOutPin_ff <= ctOut_ff;                                             // [R21] [R22]
      end else begin
         timerOutPin_ff <= outPortBit3;
      end
   end

   // read mux; unmapped and command addresses read back as zero
   always_comb begin
      nxt_rdData = READ_ZERO;
      unique case (busIn.addr)
         IRQ_STATUS_REG_ADDR: begin
            nxt_rdData[CT_READY_BIT] = ctReady_ff;
         end
         LIVE_COUNT_UPPER_ADDR: begin
            nxt_rdData = count_ff[15:8];                                         // [R23] [R10]
         end
         LIVE_COUNT_LOWER_ADDR: begin
            nxt_rdData = count_ff[7:0];                                          // [R23] [R10]
         end
         default: begin
            nxt_rdData = READ_ZERO;
         end
      endcase
   end

   // count bytes are live, so a running count can tear between reads
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdData_ff <= READ_ZERO;
      end else if (rdStart) begin
         rdData_ff <= nxt_rdData;
      end
   end

endmodule // dcut_counter_timer

// file: dv/dcut_host.sv
// host cpu model on the parallel register bus
`timescale 1ns/1ps
module dcut_host
   import dcut_pkg::*;
(
   input  wire logic sys_clk,
   output dcut_bus_t busOut,
   output logic      rdSeen
);
   initial begin
      busOut = '{1'h1, 1'h1, 1'h1, 4'h0, 8'h00};
      rdSeen = 1'h0;
   end
   // one access, one idle cycle; released lines invert so stale data never looks good
   task automatic access(input logic isRd, input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      busOut <= '{1'h0, !isRd, isRd, a, d};
      @(posedge sys_clk);
      busOut <= '{1'h1, 1'h1, 1'h1, ~a, ~d};
      rdSeen <= isRd;
      @(posedge sys_clk);
      rdSeen <= 1'h0;
   endtask
endmodule // dcut_host

// file: dv/dcut_counter_timer_chk.sv
// assertions on the counter/timer ports
`timescale 1ns/1ps
module dcut_counter_timer_chk
   import dcut_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       reset_n,
   input wire dcut_bus_t  busIn,
   input wire dcut_rx_t   rxIn,
   input wire logic       extTick,
   input wire logic       xtalTick,
   input wire logic       outPortBit3,
   input wire logic [7:0] rdData_ff,
   input wire logic       irqReqN_ff,
   input wire logic       ctOut_ff,
   input wire logic       baudClk_ff,
   input wire logic       timerOutPin_ff
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   logic actv, rdStart, wrStart, anyTick, cause;
   logic prevAct_ff, maskSh_ff, timerSh_ff, srcSh_ff;
   assign actv = !busIn.csN && !(busIn.rdN && busIn.wrN);
   assign rdStart = actv && !prevAct_ff && !busIn.rdN;
   assign wrStart = actv && !prevAct_ff && busIn.rdN;
   // raw tick of the selected source, a superset of its divided ticks
   assign anyTick = srcSh_ff ? xtalTick : extTick;
   assign cause = anyTick || rdStart || rxIn.fifoLoadA || rxIn.fifoLoadB;
   // shadows of mask, mode and source, which the ports do not show
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         prevAct_ff <= 1'h0;
         maskSh_ff  <= 1'h0;
         timerSh_ff <= 1'h0;
         srcSh_ff   <= 1'h0;
      end else begin
         prevAct_ff <= actv;
         if (wrStart && busIn.addr == IRQ_MASK_REG_ADDR) maskSh_ff <= busIn.wrData[CT_READY_BIT];
         if (wrStart && busIn.addr == AUX_CONTROL_REG_ADDR) timerSh_ff <= busIn.wrData[CT_MODE_BIT];
         if (wrStart && busIn.addr == AUX_CONTROL_REG_ADDR) srcSh_ff <= busIn.wrData[CT_SRC_MSB];
      end
   end
   a_irq_needs_mask: assert property (!irqReqN_ff |-> $past(maskSh_ff))
      else $error("irq low with mask clear");
   // a tick near the stop may set ready again, and set wins
   a_stop_drops_irq: assert property (
      rdStart && busIn.addr == STOP_COMMAND_ADDR && !anyTick && !$past(anyTick) && !$past(anyTick, 2)
      |-> ##[2:3] irqReqN_ff) else $error("irq low after stop read");
   a_status_bits: assert property (
      rdStart && busIn.addr == IRQ_STATUS_REG_ADDR |=> (rdData_ff & 8'hF7) == 8'h00)
      else $error("status read has extra bits");
   a_unmapped_zero: assert property (rdStart && busIn.addr == 4'h0 |=> rdData_ff == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (!$past(rdStart) && !$past(rdStart, 2) |-> $stable(rdData_ff))
      else $error("read data moved without read");
   a_baud_follows: assert property (baudClk_ff == $past(ctOut_ff))
      else $error("baud clock not output delayed");
   a_out_has_cause: assert property (
      $changed(ctOut_ff) |-> $past(cause) || $past(cause, 2) || $past(cause, 3))
      else $error("output moved without tick or command");
   a_start_high: assert property (
      rdStart && busIn.addr == START_COMMAND_ADDR && timerSh_ff |-> ##[1:2] ctOut_ff)
      else $error("timer start left output low");
   c_irq: cover property (!irqReqN_ff);
   c_rise: cover property ($rose(ctOut_ff));
   c_stop: cover property (rdStart && busIn.addr == STOP_COMMAND_ADDR);
endmodule // dcut_counter_timer_chk

// file: dv/dcut_counter_timer_tb.sv
// self-checking bench for the counter/timer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
   $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module dcut_counter_timer_tb
   import dcut_pkg::*;
;
   logic       sys_clk = 1'h0;
   logic       reset_n = 1'h0;
   dcut_bus_t  busIn;
   dcut_rx_t   rxIn = '0;
   logic       extTick = 1'h0;
   logic       xtalTick = 1'h0;
   logic       outPortBit3 = 1'h0;
   logic [7:0] rdData;
   logic       irqN, ctOut, baud, pin, rdSeen;
   logic [8:0] expQ[$];
   logic [8:0] note;
   logic [15:0] rVal;
   int         fail_count = 0;
   int         n_tests = 0;
   dcut_counter_timer u_dcut_counter_timer(.sys_clk(sys_clk), .reset_n(reset_n), .busIn(busIn), .rxIn(rxIn),
      .extTick(extTick), .xtalTick(xtalTick), .outPortBit3(outPortBit3), .rdData_ff(rdData),
      .irqReqN_ff(irqN), .ctOut_ff(ctOut), .baudClk_ff(baud), .timerOutPin_ff(pin));
   dcut_host u_dcut_host(.sys_clk(sys_clk), .busOut(busIn), .rdSeen(rdSeen));
   always #4 sys_clk = ~sys_clk;
   // noise on the unselected source must never count
   always @(posedge sys_clk) extTick <= 1'($urandom);
   // bit 8 of a note marks a command read with unspecified data
   always @(posedge sys_clk) begin
      if (rdSeen === 1'h1) begin
         note = expQ.pop_front();
         if (!note[8]) `CHK("rdData", note[7:0], rdData)
      end
   end
   task automatic tally_and_finish;
      $display("mismatches %0d of %0d checks", fail_count, n_tests);
      if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      u_dcut_host.access(1'h0, a, d);
   endtask
   task automatic rd(input logic [3:0] a, input logic [8:0] e);
      expQ.push_back(e);
      u_dcut_host.access(1'h1, a, 8'h00);
   endtask
   task automatic cnt(input logic [15:0] v);
      rd(LIVE_COUNT_UPPER_ADDR, {1'h0, v[15:8]});
      rd(LIVE_COUNT_LOWER_ADDR, {1'h0, v[7:0]});
   endtask
   task automatic reload(input logic [15:0] v);
      wr(RELOAD_UPPER_BYTE_ADDR, v[15:8]);
      wr(RELOAD_LOWER_BYTE_ADDR, v[7:0]);
   endtask
   task automatic ticks(input int n);
      @(posedge sys_clk);
      xtalTick <= 1'h1;
      repeat (n) @(posedge sys_clk);
      xtalTick <= 1'h0;
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic fifo(input logic b);
      @(posedge sys_clk);
      rxIn.fifoLoadA <= !b;
      rxIn.fifoLoadB <= b;
      @(posedge sys_clk);
      rxIn.fifoLoadA <= 1'h0;
      rxIn.fifoLoadB <= 1'h0;
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic waitIrq(input logic v);
      int c;
      c = 0;
      while (irqN !== v && c < 40) begin @(posedge sys_clk); c++; end
      `CHK("irq", v, irqN)
      if (irqN !== v) tally_and_finish();
   endtask
   // second full rise-to-rise span (third pass of the loop), past any reload change
   task automatic period(input int e);
      int c;
      for (int k = 0; k < 3; k++) begin
         c = 0;
         while (ctOut === 1'h1 && c < 99) begin @(posedge sys_clk); c++; end
         while (ctOut !== 1'h1 && c < 99) begin @(posedge sys_clk); c++; end
      end
      `CHK("period", e, c)
      if (c >= 99) tally_and_finish();
   endtask
   initial begin
      void'($urandom(79));
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'h1;
      cnt(16'h0000);
      rd(4'h0, 9'h000);
      rd(IRQ_STATUS_REG_ADDR, 9'h000);
      wr(AUX_CONTROL_REG_ADDR, 8'h20);
      wr(IRQ_MASK_REG_ADDR, 8'h08);
      reload(16'h0003);
      rd(START_COMMAND_ADDR, 9'h100);
      cnt(16'h0003);
      ticks(3);
      waitIrq(1'h0);
      rd(IRQ_STATUS_REG_ADDR, 9'h008);
      wr(IRQ_MASK_REG_ADDR, 8'h00);
      waitIrq(1'h1);
      wr(IRQ_MASK_REG_ADDR, 8'h08);
      reload(16'h0009);
      ticks(2);
      cnt(16'hFFFE);
      rd(STOP_COMMAND_ADDR, 9'h100);
      waitIrq(1'h1);
      ticks(3);
      cnt(16'hFFFE);
      rd(START_COMMAND_ADDR, 9'h100);
      cnt(16'h0009);
      wr(AUX_CONTROL_REG_ADDR, 8'h60);
      reload(16'h0002);
      rd(START_COMMAND_ADDR, 9'h100);
      wr(OUTPORT_CONFIG_REG_ADDR, 8'h04);
      xtalTick <= 1'h1;
      period(4);
      waitIrq(1'h0);
      reload(16'h0003);
      period(6);
      xtalTick <= 1'h0;
      rd(STOP_COMMAND_ADDR, 9'h100);
      waitIrq(1'h1);
      xtalTick <= 1'h1;
      period(6);
      xtalTick <= 1'h0;
      repeat (4) @(posedge sys_clk);
      `CHK("pin3", 1'h1, pin)
      `CHK("baud", 1'h1, baud)
      wr(OUTPORT_CONFIG_REG_ADDR, 8'h00);
      repeat (4) @(posedge sys_clk);
      `CHK("pin3", 1'h0, pin)
      ticks(3);
      `CHK("ctOut", 1'h0, ctOut)
      rd(START_COMMAND_ADDR, 9'h100);
      repeat (2) @(posedge sys_clk);
      `CHK("ctOut", 1'h1, ctOut)
      ticks(3);
      `CHK("ctOut", 1'h0, ctOut)
      wr(AUX_CONTROL_REG_ADDR, 8'h20);
      reload(16'h0004);
      rd(START_COMMAND_ADDR, 9'h100);
      rd(STOP_COMMAND_ADDR, 9'h100);
      rxIn.timeoutEnB <= 1'h1;
      fifo(1'h0);
      ticks(6);
      cnt(16'h0004);
      fifo(1'h1);
      ticks(3);
      fifo(1'h1);
      ticks(3);
      `CHK("irq", 1'h1, irqN)
      ticks(1);
      waitIrq(1'h0);
      // divided source: any 16 crystal ticks hold exactly one counter tick
      rVal = 16'($urandom_range(32'h0000FFFF, 32'h00000002));
      wr(AUX_CONTROL_REG_ADDR, 8'h30);
      reload(rVal);
      rd(START_COMMAND_ADDR, 9'h100);
      ticks(16);
      cnt(rVal - 16'h0001);
      tally_and_finish();
   end
endmodule // dcut_counter_timer_tb
bind dcut_counter_timer dcut_counter_timer_chk u_chk(.sys_clk(sys_clk), .reset_n(reset_n), .busIn(busIn),
   .rxIn(rxIn), .extTick(extTick), .xtalTick(xtalTick), .outPortBit3(outPortBit3), .rdData_ff(rdData_ff),
   .irqReqN_ff(irqReqN_ff), .ctOut_ff(ctOut_ff), .baudClk_ff(baudClk_ff), .timerOutPin_ff(timerOutPin_ff));
